// ==== design/dbgms_top.sv ====
/*
 * Debug pin logic: mode select while a qualifying reset is in progress,
 * then a serial debug line with bit-level timing.
 * Assumes the debug clock enable comes from logic on clk; the pin is
 * resolved as open drain with pullup outside this module.
 */
`timescale 1ns/10ps
`default_nettype none
module dbgms_top
	import dbgms_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic qual_reset,
	input  wire logic debug_clk_en,
	input  wire logic pin_in,
	output var  logic pin_out,
	output var  logic pin_oe,
	input  wire logic tx_start,
	input  wire logic tx_bit,
	output var  logic bg_mode,
	output var  logic link_active,
	output var  logic rx_valid,
	output var  logic rx_bit,
	output var  logic busy
);

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	logic [2:0] sync_r;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			sync_r <= SYNC_RST;
		else
			sync_r <= {sync_r[1:0], pin_in};

	// change counts only when stages two and three agree
	logic pin_s_r;
	wire  agree = (sync_r[1] == sync_r[2]);
	always_ff @(posedge clk or posedge rst)
		if (rst)
			pin_s_r <= 1'b1;
		else if (agree)
			pin_s_r <= sync_r[2];

	// ----------------------------------------
	// mode latch
	// ----------------------------------------
	logic qual_d_r;
	wire  qual_fall = qual_d_r & ~qual_reset;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			qual_d_r <= 1'b0;
		else
			qual_d_r <= qual_reset;

	// apart from rst, which loads MODE_RST, only the qualifying reset release (qual_fall) changes the mode
	always_ff @(posedge clk or posedge rst)
		if (rst)
			bg_mode <= MODE_RST;
		else if (qual_fall)
			bg_mode <= ~pin_s_r; // RULE3 RULE4 RULE8

	// ----------------------------------------
	// bit engine
	// ----------------------------------------
	dbgms_state_t state_r, state_nxt;
	logic [3:0]   cnt_r;
	logic         bit_r;
	wire          link_ok  = ~qual_reset; // RULE1 RULE2
	wire          tick     = debug_clk_en; // RULE6
	wire          cnt_last = (cnt_r == BIT_LAST);
	wire          sample   = tick & (cnt_r == SAMPLE_AT) & (state_r == DBGMS_LOW);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			DBGMS_IDLE: if (link_ok & tx_start) state_nxt = DBGMS_LOW;
			DBGMS_LOW:  if (tick & cnt_last) state_nxt = DBGMS_HIGH;
			DBGMS_HIGH: if (tick & (cnt_r == SPEEDUP_END)) state_nxt = DBGMS_IDLE;
			default:    state_nxt = DBGMS_IDLE;
		endcase
		if (!link_ok)
			state_nxt = DBGMS_IDLE;
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			state_r <= DBGMS_IDLE;
			cnt_r   <= 4'h0;
			bit_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r != state_nxt)
				cnt_r <= 4'h0;
			else if (tick)
				cnt_r <= cnt_r + 4'h1; // RULE5
			if (state_r == DBGMS_IDLE && state_nxt == DBGMS_LOW)
				bit_r <= tx_bit;
		end

	// low for 4 ticks on a one, whole bit on a zero; brief drive high after a one only
	wire drv_low  = (state_r == DBGMS_LOW) & (~bit_r | (cnt_r < ONE_LOW));
	wire drv_high = (state_r == DBGMS_HIGH) & bit_r;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			pin_out     <= 1'b1;
			pin_oe      <= 1'b0;
			rx_valid    <= 1'b0;
			rx_bit      <= 1'b0;
			busy        <= 1'b0;
			link_active <= 1'b0;
		end
		else
		begin
			pin_oe      <= drv_low | drv_high; // RULE7
			pin_out     <= drv_high; // RULE7
			rx_valid    <= sample;
			if (sample)
				rx_bit <= pin_s_r;
			busy        <= (state_nxt != DBGMS_IDLE);
			link_active <= link_ok;
		end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_no_drive_reset: assert property (@(posedge clk) disable iff (rst) // RULE1
		qual_reset |=> ##1 !pin_oe)
		else $error("pin driven during qualifying reset");

	chk_mode_latch: assert property (@(posedge clk) disable iff (rst) // RULE8
		qual_fall |=> bg_mode == $past(~pin_s_r))
		else $error("mode not latched at reset release");

	chk_mode_hold: assert property (@(posedge clk) disable iff (rst) // RULE8
		!qual_fall |=> $stable(bg_mode))
		else $error("mode changed without reset release");

	chk_low_pin_bg: assert property (@(posedge clk) disable iff (rst) // RULE4
		(qual_fall && !pin_s_r) |=> bg_mode)
		else $error("low pin did not give background mode");

	chk_link_after: assert property (@(posedge clk) disable iff (rst) // RULE2
		$fell(qual_reset) |=> link_active)
		else $error("link not active after reset");

	chk_bit_len: assert property (@(posedge clk) disable iff (rst) // RULE5
		(state_r == DBGMS_LOW && tick && cnt_last && link_ok) |=> state_r == DBGMS_HIGH)
		else $error("bit length wrong");

	chk_no_tick: assert property (@(posedge clk) disable iff (rst) // RULE6
		(state_r == DBGMS_LOW && !tick && link_ok) |=> $stable(cnt_r))
		else $error("bit timer ran without debug clock");

	chk_high_brief: assert property (@(posedge clk) disable iff (rst) // RULE7
		(pin_oe && pin_out) |-> $past(state_r == DBGMS_HIGH))
		else $error("high drive outside speedup");

	// ----------------------------------------
	// checks: slot engine and pin drive
	// ----------------------------------------
	// a slot cut by a qualifying reset must not leave the pin held low
	chk_abort_idle: assert property (@(posedge clk) disable iff (rst) // RULE1
		!link_ok |=> state_r == DBGMS_IDLE)
		else $error("slot not aborted by qualifying reset");

	chk_link_low: assert property (@(posedge clk) disable iff (rst) // RULE1
		qual_reset |=> !link_active)
		else $error("link active during qualifying reset");

	chk_busy_take: assert property (@(posedge clk) disable iff (rst) // RULE2
		(state_r == DBGMS_IDLE && link_ok && tx_start) |=> busy)
		else $error("request not taken");

	chk_busy_drop: assert property (@(posedge clk) disable iff (rst) // RULE5
		(state_r == DBGMS_HIGH && state_nxt == DBGMS_IDLE) |=> !busy)
		else $error("busy held after slot end");

	chk_tick_step: assert property (@(posedge clk) disable iff (rst) // RULE5
		(state_r == DBGMS_LOW && tick && !cnt_last && link_ok) |=> cnt_r == $past(cnt_r) + 4'h1)
		else $error("bit timer did not step on tick");

	chk_rx_once: assert property (@(posedge clk) disable iff (rst) // RULE5
		rx_valid |=> !rx_valid)
		else $error("sample pulse too long");

	chk_sample_take: assert property (@(posedge clk) disable iff (rst) // RULE5
		sample |=> rx_valid && rx_bit == $past(pin_s_r))
		else $error("mid-bit sample lost");

	chk_rx_hold: assert property (@(posedge clk) disable iff (rst) // RULE5
		!sample |=> $stable(rx_bit))
		else $error("sampled bit changed between samples");

	chk_zero_low: assert property (@(posedge clk) disable iff (rst) // RULE7
		(state_r == DBGMS_LOW && !bit_r) |=> pin_oe && !pin_out)
		else $error("zero bit not driven low");

	chk_one_release: assert property (@(posedge clk) disable iff (rst) // RULE7
		(state_r == DBGMS_LOW && bit_r && cnt_r >= ONE_LOW) |=> !pin_oe)
		else $error("one bit not released");

	chk_speedup_end: assert property (@(posedge clk) disable iff (rst) // RULE7
		(state_r == DBGMS_HIGH && tick && cnt_r == SPEEDUP_END) |=> state_r == DBGMS_IDLE)
		else $error("speedup pulse too long");

	chk_idle_release: assert property (@(posedge clk) disable iff (rst) // RULE7
		(state_r == DBGMS_IDLE) |=> !pin_oe)
		else $error("pin driven while idle");

endmodule : dbgms_top
`default_nettype wire

// ==== design/dbgms_pkg.sv ====
/*
 * Shared constants and types for the debug pin / mode select block.
 * Assumes a single 25 MHz clock and an active-high asynchronous reset.
 */
// Summary of operation
// RULE1 - pin is mode select during qualifying reset
// RULE2 - pin becomes debug line after any reset
// RULE3 - high pin at release gives normal mode
// RULE4 - low pin at release gives background mode
// RULE5 - each debug bit lasts 16 debug clocks
// RULE6 - bit timing scales with debug clock
// RULE7 - line is open drain with speedup pulses
// RULE8 - mode latched once at qualifying reset release
package dbgms_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned BIT_CYCLES   = 16;
	localparam int unsigned SAMPLE_CYCLE = 10;
	localparam int unsigned SPEEDUP_CYC  = 1;
	localparam int unsigned ONE_LOW_CYC  = 4;
	localparam logic [3:0]  ONE_LOW      = 4'(ONE_LOW_CYC);
	localparam logic [3:0]  BIT_LAST     = 4'(BIT_CYCLES - 1);
	localparam logic [3:0]  SAMPLE_AT    = 4'(SAMPLE_CYCLE);
	localparam logic [3:0]  SPEEDUP_END  = 4'(SPEEDUP_CYC);

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic        MODE_RST     = 1'b0;
	localparam logic [2:0]  SYNC_RST     = 3'h7;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		DBGMS_IDLE = 2'b00,
		DBGMS_LOW  = 2'b01,
		DBGMS_HIGH = 2'b10
	} dbgms_state_t;

	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} dbgms_pin_t;

endpackage : dbgms_pkg

// ==== testbench/dbgms_pod.sv ====
/* far-side debug pod: resolves the open-drain pin with its pullup.
   assumes the bench sets hold_low. */
`timescale 1ns/10ps
`default_nettype none
module dbgms_pod
(
	input  wire logic pin_oe,
	input  wire logic pin_out,
	input  wire logic hold_low,
	output var  logic pin
);
	// ----------------
	// resolution
	// ----------------
	// released line rises by pullup; speedup drive is high too
	assign pin = ~((pin_oe & ~pin_out) | hold_low);
endmodule : dbgms_pod
`default_nettype wire

// ==== testbench/dbgms_top_tb.sv ====
/* bench for dbgms_top: mode select, bit slots, refusal.
   assumes dbgms_pod resolves the pin. */
`timescale 1ns/10ps
`default_nettype none
module dbgms_top_tb;
	import dbgms_pkg::*;
	logic clk, rst, qual, en, txs, txb, low, pin, po, poe, bgm, lnk, rv, rb, bsy;
	int   err_total, checks_done, div, ph = 0;
	dbgms_pod pod (.pin_oe(poe), .pin_out(po), .hold_low(low), .pin(pin));
	dbgms_top DUT (.clk(clk), .rst(rst), .qual_reset(qual), .debug_clk_en(en),
		.pin_in(pin), .pin_out(po), .pin_oe(poe), .tx_start(txs), .tx_bit(txb),
		.bg_mode(bgm), .link_active(lnk), .rx_valid(rv), .rx_bit(rb), .busy(bsy));
	// ----------------
	// helpers
	// ----------------
	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	// tick divider, so bit timing follows the debug clock
	always @(negedge clk)
	begin
		en <= (ph >= div - 1);
		ph <= (ph >= div - 1) ? 0 : ph + 1;
	end
	task automatic chk(input logic seen, input logic exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL %0t value mismatch", $time);
		end
	endtask : chk
	task automatic close_out;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	// ----------------
	// scenarios
	// ----------------
	task automatic mode_sel(input logic hold);
		@(negedge clk);
		qual = 1;
		low = hold;
		repeat (6) @(negedge clk);
		chk(lnk, 1'b0);
		qual = 0;
		repeat (3) @(negedge clk);
		low = 0;
		repeat (3) @(negedge clk);
		chk(bgm, hold);
		chk(lnk, 1'b1);
	endtask : mode_sel
	task automatic slot(input logic b, input int d);
		int lo, su, rc, n, l;
		lo = 0; su = 0; rc = 0; n = 0; div = d;
		l = b ? 4 : BIT_CYCLES;
		@(negedge clk);
		txs = 1;
		txb = b;
		@(negedge clk);
		txs = 0;
		do
		begin
			@(negedge clk);
			n++;
			lo += (poe & ~po);
			su += (poe & po);
			rc += rv;
			if (rv)
				chk(rb, b);
		end while ((bsy === 1'b1 || n < 3) && n < 2000);
		if (n >= 2000)
		begin
			err_total++;
			close_out();
		end
		chk(lo >= l * d - d && lo <= l * d + d, 1'b1);
		chk(su != 0, b);
		chk(rc == 1, 1'b1);
	endtask : slot
	task automatic refuse;
		@(negedge clk);
		qual = 1;
		txs = 1;
		repeat (4) @(negedge clk);
		chk(bsy, 1'b0);
		chk(poe, 1'b0);
		txs = 0;
		qual = 0;
		repeat (3) @(negedge clk);
	endtask : refuse
	task automatic rst_mid;
		mode_sel(1'b1);
		@(negedge clk);
		rst = 1;
		@(negedge clk);
		chk(bgm, MODE_RST);
		chk(poe, 1'b0);
		rst = 0;
		repeat (2) @(negedge clk);
		chk(bsy, 1'b0);
		chk(lnk, 1'b1);
	endtask : rst_mid
	initial
	begin
		rst = 1;
		qual = 1;
		txs = 0;
		txb = 0;
		low = 0;
		div = 1;
		err_total = 0;
		checks_done = 0;
		repeat (10) @(negedge clk);
		rst = 0;
		mode_sel(1'b1);
		mode_sel(1'b0);
		rst_mid();
		slot(1'b0, 1);
		slot(1'b1, 1);
		slot(1'b0, 3);
		slot(1'b1, 3);
		refuse();
		close_out();
	end
endmodule : dbgms_top_tb
`default_nettype wire
